//--- src/tcrr_pkg.sv
// What this block does
// - enabled high byte read latches low byte
// - enabled low read returns latched byte
// - disabled low read returns live byte
// - count byte write loads next edge
// - count is high byte then low
// - reload high write is only held
// - reload low write commits both bytes
// - count at reload returns to 0001H
// - compare mode compares against duty and reload pairs
// - duty match toggles pulse output except in pwm single and capture modes
// - output levels follow polarity bit
// - capture modes store count in duty
// - mode is top bit over 3-bit field
// - pwm single: match drives inverse of polarity bit, reload drives polarity bit
package tcrr_pkg;
	localparam logic [11:0] ADDR_COUNT_HI = 12'hF00;
	localparam logic [11:0] ADDR_COUNT_LO = 12'hF01;
	localparam logic [11:0] ADDR_RELOAD_HI = 12'hF02;
	localparam logic [11:0] ADDR_RELOAD_LO = 12'hF03;
	localparam logic [11:0] ADDR_DUTY_HI = 12'hF04;
	localparam logic [11:0] ADDR_DUTY_LO = 12'hF05;
	localparam logic [11:0] ADDR_CTL0 = 12'hF06;
	localparam logic [11:0] ADDR_CTL1 = 12'hF07;
	localparam logic [11:0] ADDR_CAPTURE = 12'hF08;
	localparam logic [7:0] RST_COUNT_HI = 8'h00;
	localparam logic [7:0] RST_COUNT_LO = 8'h01;
	localparam logic [7:0] RST_RELOAD = 8'hFF;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [15:0] COUNT_RESTART = 16'h0001;
	localparam int CTL0_MODE_TOP_POS = 7;
	localparam int CTL1_ENABLE_POS = 7;
	localparam int CTL1_POLARITY_POS = 6;
	localparam int CTL1_PRESCALE_POS = 3;
	localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
	localparam logic [3:0] MODE_CAPTURE = 4'h4;
	localparam logic [3:0] MODE_COMPARE = 4'h5;
	localparam logic [3:0] MODE_CAPTURE_COMPARE = 4'h7;
	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] lower;
	} tcrr_word_t;
endpackage

//--- src/tcrr_prescaler.sv
`timescale 1ns/100ps
module tcrr_prescaler (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] shift,
	output logic tick
);
	logic [6:0] cnt;
	logic [6:0] next_cnt;
	logic [6:0] limit;
	always_comb begin
		limit = 7'((8'h01 << shift) - 8'h01);
		next_cnt = cnt;
		tick = 1'b0;
		if (!run) begin
			next_cnt = 7'h00;
		end else if (cnt >= limit) begin
			next_cnt = 7'h00;
			tick = 1'b1;
		end else begin
			next_cnt = cnt + 7'h01;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt <= 7'h00;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule

//--- src/tcrr_top.sv
// Local design decision: register access over APB.
`timescale 1ns/100ps
module tcrr_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_strobe,
	output logic pulse_out
);
	// ****************************************
	// state
	// ****************************************
	tcrr_pkg::tcrr_word_t count, next_count;
	tcrr_pkg::tcrr_word_t reload, next_reload;
	tcrr_pkg::tcrr_word_t duty, next_duty;
	logic [7:0] reload_hold, next_reload_hold;
	logic [7:0] low_hold, next_low_hold;
	logic [7:0] ctl0, next_ctl0;
	logic [7:0] ctl1, next_ctl1;
	logic next_pulse_out;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic tick;
	logic enabled;
	logic polarity;
	logic [3:0] mode;
	logic access;
	logic wr;
	logic rd;
	logic at_reload;
	logic duty_match;
	logic [7:0] wbyte;
	logic mapped;

	assign enabled = ctl1[tcrr_pkg::CTL1_ENABLE_POS];
	assign polarity = ctl1[tcrr_pkg::CTL1_POLARITY_POS];
	assign mode = {ctl0[tcrr_pkg::CTL0_MODE_TOP_POS], ctl1[2:0]};
	assign access = psel && penable && !pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign wbyte = pwdata[7:0];
	assign at_reload = (count == reload);
	assign duty_match = (count == duty);

	tcrr_prescaler u_prescaler (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(enabled),
		.shift(ctl1[tcrr_pkg::CTL1_PRESCALE_POS +: 3]),
		.tick(tick)
	);

	// ****************************************
	// address decode
	// ****************************************
	always_comb begin
		unique case (paddr)
			tcrr_pkg::ADDR_COUNT_HI, tcrr_pkg::ADDR_COUNT_LO,
			tcrr_pkg::ADDR_RELOAD_HI, tcrr_pkg::ADDR_RELOAD_LO,
			tcrr_pkg::ADDR_DUTY_HI, tcrr_pkg::ADDR_DUTY_LO,
			tcrr_pkg::ADDR_CTL0, tcrr_pkg::ADDR_CTL1,
			tcrr_pkg::ADDR_CAPTURE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************
	// counter and registers
	// ****************************************
	always_comb begin
		next_count = count;
		next_reload = reload;
		next_duty = duty;
		next_reload_hold = reload_hold;
		next_low_hold = low_hold;
		next_ctl0 = ctl0;
		next_ctl1 = ctl1;
		next_pulse_out = pulse_out;
		if (enabled && tick) begin
			if (at_reload) begin
				next_count = tcrr_pkg::COUNT_RESTART;
			end else begin
				next_count = count + 16'h0001;
			end
		end
		if (!enabled) begin
			next_pulse_out = polarity;
		end else if (mode == tcrr_pkg::MODE_PWM_SINGLE) begin
			if (enabled && tick && at_reload) begin
				next_pulse_out = polarity;
			end else if (duty_match) begin
				next_pulse_out = !polarity;
			end
		end else if (enabled && tick && at_reload) begin
			next_pulse_out = !pulse_out;
		end else if (duty_match && tick && mode != tcrr_pkg::MODE_CAPTURE
			&& mode != tcrr_pkg::MODE_CAPTURE_COMPARE) begin
			next_pulse_out = !pulse_out;
		end
		if (enabled && capture_strobe && (mode == tcrr_pkg::MODE_CAPTURE
			|| mode == tcrr_pkg::MODE_CAPTURE_COMPARE)) begin
			next_duty = count;
		end
		if (rd && paddr == tcrr_pkg::ADDR_COUNT_HI && enabled) begin
			next_low_hold = count.lower;
		end
		if (wr) begin
			unique case (paddr)
				tcrr_pkg::ADDR_COUNT_HI: next_count.upper = wbyte;
				tcrr_pkg::ADDR_COUNT_LO: next_count.lower = wbyte;
				tcrr_pkg::ADDR_RELOAD_HI: next_reload_hold = wbyte;
				tcrr_pkg::ADDR_RELOAD_LO: next_reload = {reload_hold, wbyte};
				tcrr_pkg::ADDR_DUTY_HI: next_duty.upper = wbyte;
				tcrr_pkg::ADDR_DUTY_LO: next_duty.lower = wbyte;
				tcrr_pkg::ADDR_CTL0: next_ctl0 = wbyte;
				tcrr_pkg::ADDR_CTL1: next_ctl1 = wbyte;
				default: ;
			endcase
		end
	end

	// ****************************************
	// apb answer
	// ****************************************
	always_comb begin
		next_pready = access;
		next_pslverr = access && !mapped;
		next_prdata = 32'h0000_0000;
		if (rd) begin
			unique case (paddr)
				tcrr_pkg::ADDR_COUNT_HI: next_prdata = {24'h000000, count.upper};
				tcrr_pkg::ADDR_COUNT_LO: next_prdata = {24'h000000,
					enabled ? low_hold : count.lower};
				tcrr_pkg::ADDR_RELOAD_HI: next_prdata = {24'h000000, reload.upper};
				tcrr_pkg::ADDR_RELOAD_LO: next_prdata = {24'h000000, reload.lower};
				tcrr_pkg::ADDR_DUTY_HI: next_prdata = {24'h000000, duty.upper};
				tcrr_pkg::ADDR_DUTY_LO: next_prdata = {24'h000000, duty.lower};
				tcrr_pkg::ADDR_CTL0: next_prdata = {24'h000000, ctl0};
				tcrr_pkg::ADDR_CTL1: next_prdata = {24'h000000, ctl1};
				tcrr_pkg::ADDR_CAPTURE: next_prdata = {16'h0000, count};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count <= {tcrr_pkg::RST_COUNT_HI, tcrr_pkg::RST_COUNT_LO};
			reload <= {tcrr_pkg::RST_RELOAD, tcrr_pkg::RST_RELOAD};
			duty <= {tcrr_pkg::RST_DUTY, tcrr_pkg::RST_DUTY};
			reload_hold <= tcrr_pkg::RST_RELOAD;
			low_hold <= 8'h00;
			ctl0 <= 8'h00;
			ctl1 <= 8'h00;
			pulse_out <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			count <= next_count;
			reload <= next_reload;
			duty <= next_duty;
			reload_hold <= next_reload_hold;
			low_hold <= next_low_hold;
			ctl0 <= next_ctl0;
			ctl1 <= next_ctl1;
			pulse_out <= next_pulse_out;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_latch_low;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == tcrr_pkg::ADDR_COUNT_HI && enabled && !wr)
			|=> (low_hold == $past(count.lower));
	endproperty
	a_latch_low: assert property (p_latch_low) else $error("low byte not latched");

	property p_low_read_held;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == tcrr_pkg::ADDR_COUNT_LO && enabled) |=> (prdata[7:0] == $past(low_hold));
	endproperty
	a_low_read_held: assert property (p_low_read_held) else $error("low read not held");

	property p_low_read_live;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == tcrr_pkg::ADDR_COUNT_LO && !enabled)
			|=> (prdata[7:0] == $past(count.lower));
	endproperty
	a_low_read_live: assert property (p_low_read_live) else $error("low read not live");

	property p_count_write;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr && paddr == tcrr_pkg::ADDR_COUNT_HI) |=> (count.upper == $past(wbyte));
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	property p_reload_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr && paddr == tcrr_pkg::ADDR_RELOAD_HI) |=> (reload == $past(reload));
	endproperty
	a_reload_hold: assert property (p_reload_hold) else $error("reload changed early");

	property p_reload_commit;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr && paddr == tcrr_pkg::ADDR_RELOAD_LO)
			|=> (reload == {$past(reload_hold), $past(wbyte)});
	endproperty
	a_reload_commit: assert property (p_reload_commit) else $error("reload not committed");

	property p_restart;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && tick && at_reload && !wr) |=> (count == tcrr_pkg::COUNT_RESTART);
	endproperty
	a_restart: assert property (p_restart) else $error("no restart at reload");

	property p_capture;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && capture_strobe && mode == tcrr_pkg::MODE_CAPTURE && !wr)
			|=> (duty == $past(count));
	endproperty
	a_capture: assert property (p_capture) else $error("capture not stored");

	property p_pwm_reload;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && tick && at_reload && mode == tcrr_pkg::MODE_PWM_SINGLE)
			|=> (pulse_out == $past(polarity));
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload level");

	property p_idle_level;
		@(posedge sys_clk) disable iff (!rst_n)
		!enabled |=> (pulse_out == $past(polarity));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

	property p_pwm_match;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && mode == tcrr_pkg::MODE_PWM_SINGLE && duty_match && !(tick && at_reload))
			|=> (pulse_out == !$past(polarity));
	endproperty
	a_pwm_match: assert property (p_pwm_match) else $error("pwm match level");

	property p_duty_toggle;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && tick && duty_match && !at_reload && mode != tcrr_pkg::MODE_PWM_SINGLE
			&& mode != tcrr_pkg::MODE_CAPTURE && mode != tcrr_pkg::MODE_CAPTURE_COMPARE)
			|=> (pulse_out != $past(pulse_out));
	endproperty
	a_duty_toggle: assert property (p_duty_toggle) else $error("no toggle on match");

	property p_capture_word;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd && paddr == tcrr_pkg::ADDR_CAPTURE) |=> (prdata == {16'h0000, $past(count)});
	endproperty
	a_capture_word: assert property (p_capture_word) else $error("count word wrong");

	property p_increment;
		@(posedge sys_clk) disable iff (!rst_n)
		(enabled && tick && !at_reload && !wr) |=> (count == 16'($past(count) + 16'h0001));
	endproperty
	a_increment: assert property (p_increment) else $error("count not advanced");
endmodule

//--- testbench/tcrr_apb_master.sv
`timescale 1ns/100ps
module tcrr_apb_master (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one transfer: setup, then access held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

//--- testbench/test_timer_count_reload_regs.sv
`timescale 1ns/100ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin num_errors++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module test_timer_count_reload_regs;
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [7:0] d;
		logic [7:0] r;
		logic e;
	} tcrr_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic capture_strobe = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, pulse_out, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] r, h, l1, l2;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	// ordinary accesses with the timer stopped
	tcrr_row_t rows [16] = '{
		'{1'h0, 12'hF00, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'hF01, 8'h00, 8'h01, 1'h0},
		'{1'h0, 12'hF02, 8'h00, 8'hFF, 1'h0}, '{1'h0, 12'hF03, 8'h00, 8'hFF, 1'h0},
		'{1'h0, 12'hF04, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'hF05, 8'h00, 8'h00, 1'h0},
		'{1'h1, 12'hF02, 8'h12, 8'h00, 1'h0}, '{1'h1, 12'hF03, 8'h34, 8'h00, 1'h0},
		'{1'h0, 12'hF02, 8'h00, 8'h12, 1'h0}, '{1'h0, 12'hF03, 8'h00, 8'h34, 1'h0},
		'{1'h1, 12'hF00, 8'hAB, 8'h00, 1'h0}, '{1'h1, 12'hF01, 8'hCD, 8'h00, 1'h0},
		'{1'h0, 12'hF00, 8'h00, 8'hAB, 1'h0}, '{1'h0, 12'hF01, 8'h00, 8'hCD, 1'h0},
		'{1'h0, 12'hF08, 8'h00, 8'hCD, 1'h0}, '{1'h0, 12'h010, 8'h00, 8'h00, 1'h1}};
	always #4 sys_clk = ~sys_clk;
	tcrr_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_strobe(capture_strobe), .pulse_out(pulse_out));
	tcrr_apb_master u_mst (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		u_mst.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		u_mst.xfer(1'b0, a, 8'h00, v, e);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		`CHK(pulse_out, 1'b0)
		foreach (rows[i]) begin
			u_mst.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
			if (!rows[i].w) `CHK(r, rows[i].r)
			`CHK(e, rows[i].e)
		end
		$display("table done");
		wr(12'hF07, 8'h40);
		repeat (2) @(posedge sys_clk);
		`CHK(pulse_out, 1'b1)
		wr(12'hF07, 8'h00);
		$display("polarity done");
		wr(12'hF02, 8'h00);
		rd(12'hF02, r);
		`CHK(r, 8'h12)
		wr(12'hF03, 8'h10);
		rd(12'hF02, r);
		`CHK(r, 8'h00)
		wr(12'hF05, 8'h08);
		wr(12'hF00, 8'h00);
		wr(12'hF01, 8'h01);
		// compare mode, divide by one: 64 ticks wrap the 16-step cycle back to 0001
		wr(12'hF07, 8'h85);
		repeat (60) @(posedge sys_clk);
		wr(12'hF07, 8'h00);
		rd(12'hF00, h);
		rd(12'hF01, l1);
		`CHK({h, l1}, 16'h0001)
		$display("reload done");
		wr(12'hF02, 8'hFF);
		wr(12'hF03, 8'hFF);
		wr(12'hF01, 8'h10);
		wr(12'hF07, 8'h80);
		rd(12'hF00, h);
		rd(12'hF01, l1);
		repeat (10) @(posedge sys_clk);
		rd(12'hF01, l2);
		`CHK(h, 8'h00)
		`CHK(l1, 8'h13)
		`CHK(l2, l1)
		wr(12'hF01, 8'h00);
		wr(12'hF00, 8'h55);
		rd(12'hF00, r);
		`CHK(r, 8'h55)
		wr(12'hF07, 8'h00);
		$display("latch done");
		wr(12'hF00, 8'h05);
		wr(12'hF01, 8'h00);
		wr(12'hF07, 8'h84);
		capture_strobe <= 1'b1;
		@(posedge sys_clk);
		capture_strobe <= 1'b0;
		wr(12'hF07, 8'h04);
		rd(12'hF04, r);
		`CHK(r, 8'h05)
		rd(12'hF05, r);
		`CHK(r, 8'h01)
		// mode top bit set: 1100 is not capture, so the strobe must not store
		wr(12'hF06, 8'h80);
		wr(12'hF07, 8'h84);
		capture_strobe <= 1'b1;
		@(posedge sys_clk);
		capture_strobe <= 1'b0;
		wr(12'hF07, 8'h04);
		wr(12'hF06, 8'h00);
		rd(12'hF05, r);
		`CHK(r, 8'h01)
		$display("capture done");
		wr(12'hF02, 8'h00);
		wr(12'hF03, 8'h08);
		wr(12'hF04, 8'h00);
		wr(12'hF05, 8'h04);
		wr(12'hF00, 8'h00);
		wr(12'hF01, 8'h01);
		wr(12'hF07, 8'h83);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(pulse_out, 1'b1)
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(pulse_out, 1'b0)
		$display("pwm done");
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		`CHK(pulse_out, 1'b0)
		rd(12'hF01, r);
		`CHK(r, 8'h01)
		rd(12'hF02, r);
		`CHK(r, 8'hFF)
		rd(12'hF03, r);
		`CHK(r, 8'hFF)
		$display("reset done");
		final_report;
	end
endmodule
